/* hw/wdtcfg_pkg.sv */
// Package for the watchdog configuration block: map, fields, constants
package wdtcfg_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'hc;
  localparam int unsigned BIT_IRQ_FLAG = 7;
  localparam int unsigned BIT_IRQ_EN = 6;
  localparam int unsigned BIT_PRE_HI = 5;
  localparam int unsigned BIT_CHG_EN = 4;
  localparam int unsigned BIT_RST_EN = 3;
  localparam int unsigned BIT_CAUSE = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] PRE_MAX = 4'h9;
  localparam int unsigned BASE_LOG2 = 11;
  localparam int unsigned CNT_W = 21;
  localparam logic [2:0] CHG_WINDOW = 3'h4;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_TIMEOUT = 16'h000c;
  localparam logic [5:0] VEC_NUM_TIMEOUT = 6'h07;
  localparam int unsigned EV_W = 2;
  localparam int unsigned EV_IRQ = 0;
  localparam int unsigned EV_RST = 1;
  typedef enum logic [3:0] {
    WDTCFG_STOP = 4'b0001,
    WDTCFG_IRQ = 4'b0010,
    WDTCFG_RST = 4'b0100,
    WDTCFG_IRQ_RST = 4'b1000
  } wdtcfg_mode_type;
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } wdtcfg_bus_req_type;
endpackage

/* hw/wdtcfg_counter.sv */
// Time-out counter on core_clk, counting watchdog oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module wdtcfg_counter #(
  parameter int unsigned CNT_W = wdtcfg_pkg::CNT_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic osc_tick,
  input wire logic restart,
  input wire logic run,
  input wire logic [3:0] prescale,
  output logic timeout
);
  import wdtcfg_pkg::*;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] limit;
  if (CNT_W < BASE_LOG2 + 10) begin : g_width_check
    $error("counter too narrow");
  end
  // Codes above the top code behave as the top code
  always_comb begin
    limit = '0;
    if (prescale > PRE_MAX) begin
      limit[BASE_LOG2 + 9] = 1'b1;
    end else begin
      limit[BASE_LOG2 + 32'(prescale)] = 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_ff <= '0;
    end else if (restart || !run) begin
      count_ff <= '0;
    end else if (osc_tick) begin
      count_ff <= (count_ff + 1'b1 >= limit) ? '0 : count_ff + 1'b1;
    end
  end
  assign timeout = run && osc_tick && !restart &&
                   (count_ff + 1'b1 >= limit);
endmodule
`default_nettype wire

/* hw/wdtcfg_top.sv */
// Watchdog configuration, mode decode and register slave
// Operation
// - Fuse off: no enables stops, irq enable interrupts, reset enable resets.
// - Fuse off, both enables: first time-out interrupts, then reset mode.
// - Fuse programmed (0): always system reset mode.
// - Reset-enable clear or prescale change only while change-enable set.
// - Change-enable self-clears four cycles after being written one.
// - Reset-cause flag set forces reset-enable to read set.
// - Prescale codes 0..9 select 2048 to 1048576 oscillator cycles.
// - Prescale msb bit 5, change-enable 4, reset-enable 3, low prescale 2..0.
// - Time-out interrupt goes to address 0x000C, vector 7.
// - Watchdog system reset starts at address 0x0000.
// - Set change-enable and reset-enable together, then new values in four.
// - Interrupt flag set on time-out; cleared by vector or write one.
// - Combined mode: vector clears enable and flag; next time-out resets.
// - Reset-cause flag set on watchdog reset; cleared by power-on or zero.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wdtcfg_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic power_on_rst,
  input wire logic always_on_fuse,
  input wire logic osc_tick,
  input wire logic wdr_instr,
  input wire logic irq_global_en,
  input wire logic vector_ack,
  input wire logic [wdtcfg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic wdt_irq,
  output logic [15:0] irq_vector_addr,
  output logic [5:0] irq_vector_num,
  output logic sys_reset,
  output logic [15:0] reset_vector_addr,
  output logic irq_out
);
  import wdtcfg_pkg::*;
  wdtcfg_bus_req_type req;
  wdtcfg_mode_type mode;
  logic timeout_irq_flag_ff;
  logic timeout_irq_enable_ff;
  logic reset_enable_bit_ff;
  logic change_enable_bit_ff;
  logic [3:0] prescale_select_ff;
  logic [2:0] chg_cnt_ff;
  logic watchdog_reset_cause_flag_ff;
  logic [EV_W-1:0] irq_stat_ff;
  logic [EV_W-1:0] irq_mask_ff;
  logic ack_ff;
  logic [31:0] avs_readdata_ff;
  logic wdt_irq_ff;
  logic sys_reset_ff;
  logic irq_out_ff;
  logic stopped_ff;
  logic timeout;
  logic wr_ctrl;
  logic wr_cause;
  logic wr_stat;
  logic wr_mask;
  logic rst_en_eff;
  logic [7:0] ctrl_view;
  logic [3:0] wr_pre;
  logic irq_fire;
  logic rst_fire;
  logic [EV_W-1:0] ev;
  logic running;

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = req.write && !ack_ff && (req.address == a);
  endfunction

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};
  assign wr_ctrl = hit(ADDR_CTRL);
  assign wr_cause = hit(ADDR_CAUSE);
  assign wr_stat = hit(ADDR_IRQ_STAT);
  assign wr_mask = hit(ADDR_IRQ_MASK);
  assign wr_pre = {req.writedata[BIT_PRE_HI], req.writedata[2:0]};
  assign rst_en_eff = reset_enable_bit_ff ||
                      watchdog_reset_cause_flag_ff;
  assign ctrl_view = {timeout_irq_flag_ff, timeout_irq_enable_ff,
                      prescale_select_ff[3], change_enable_bit_ff,
                      rst_en_eff, prescale_select_ff[2:0]};

  // Mode decode
  always_comb begin
    if (!always_on_fuse) begin
      mode = WDTCFG_RST;
    end else begin
      case ({rst_en_eff, timeout_irq_enable_ff})
        2'b00: mode = WDTCFG_STOP;
        2'b01: mode = WDTCFG_IRQ;
        2'b10: mode = WDTCFG_RST;
        2'b11: mode = WDTCFG_IRQ_RST;
        default: mode = WDTCFG_STOP;
      endcase
    end
  end
  assign running = (mode != WDTCFG_STOP);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stopped_ff <= 1'b1;
    end else begin
      stopped_ff <= !running;
    end
  end

  wdtcfg_counter #(.CNT_W(CNT_W)) u_counter (
    .core_clk(core_clk),
    .rstn(rstn),
    .osc_tick(osc_tick),
    .restart(wdr_instr || (stopped_ff && running)),
    .run(running),
    .prescale(prescale_select_ff),
    .timeout(timeout)
  );

  always_comb begin
    irq_fire = 1'b0;
    rst_fire = 1'b0;
    case (mode)
      WDTCFG_STOP: irq_fire = 1'b0;
      WDTCFG_IRQ: irq_fire = timeout;
      WDTCFG_RST: rst_fire = timeout;
      WDTCFG_IRQ_RST: begin
        // Unserviced flag means the previous interrupt was missed
        irq_fire = timeout && !timeout_irq_flag_ff;
        rst_fire = timeout && timeout_irq_flag_ff;
      end
      default: rst_fire = 1'b0;
    endcase
  end

  // Interrupt flag
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timeout_irq_flag_ff <= CTRL_RESET[BIT_IRQ_FLAG];
    end else if (irq_fire) begin
      timeout_irq_flag_ff <= 1'b1;
    end else if (vector_ack ||
                 (wr_ctrl && req.writedata[BIT_IRQ_FLAG])) begin
      timeout_irq_flag_ff <= 1'b0;
    end
  end

  // Interrupt enable; combined mode drops to reset mode on the vector
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timeout_irq_enable_ff <= CTRL_RESET[BIT_IRQ_EN];
    end else if (wr_ctrl) begin
      timeout_irq_enable_ff <= req.writedata[BIT_IRQ_EN];
    end else if (vector_ack && mode == WDTCFG_IRQ_RST) begin
      timeout_irq_enable_ff <= 1'b0;
    end
  end

  // Reset enable and prescale, guarded by change enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reset_enable_bit_ff <= CTRL_RESET[BIT_RST_EN];
      prescale_select_ff <= CTRL_RESET[3:0];
    end else begin
      // Cause flag pins the stored enable set
      if (watchdog_reset_cause_flag_ff) begin
        reset_enable_bit_ff <= 1'b1;
      end else if (wr_ctrl && req.writedata[BIT_RST_EN]) begin
        reset_enable_bit_ff <= 1'b1;
      end else if (wr_ctrl && change_enable_bit_ff) begin
        reset_enable_bit_ff <= 1'b0;
      end
      if (wr_ctrl && change_enable_bit_ff) begin
        prescale_select_ff <= wr_pre;
      end
    end
  end

  // Change enable window
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      change_enable_bit_ff <= CTRL_RESET[BIT_CHG_EN];
      chg_cnt_ff <= '0;
    end else if (wr_ctrl && req.writedata[BIT_CHG_EN] &&
                 req.writedata[BIT_RST_EN]) begin
      change_enable_bit_ff <= 1'b1;
      chg_cnt_ff <= CHG_WINDOW;
    end else if (wr_ctrl) begin
      change_enable_bit_ff <= 1'b0;
      chg_cnt_ff <= '0;
    end else if (chg_cnt_ff != '0) begin
      chg_cnt_ff <= chg_cnt_ff - 1'b1;
      if (chg_cnt_ff == 3'h1) begin
        change_enable_bit_ff <= 1'b0;
      end
    end
  end

  // Reset-cause flag
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_reset_cause_flag_ff <= 1'b0;
    end else if (rst_fire) begin
      watchdog_reset_cause_flag_ff <= 1'b1;
    end else if (power_on_rst ||
                 (wr_cause && !req.writedata[BIT_CAUSE])) begin
      watchdog_reset_cause_flag_ff <= 1'b0;
    end
  end

  // Event status and mask
  assign ev = {rst_fire, irq_fire};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= ev |
        (irq_stat_ff & ~(wr_stat ? req.writedata[EV_W-1:0] : '0));
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_ff <= '0;
    end else if (wr_mask) begin
      irq_mask_ff <= req.writedata[EV_W-1:0];
    end
  end

  // Bus slave: one wait cycle, answer on the second edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
      avs_readdata_ff <= '0;
    end else begin
      ack_ff <= (req.read || req.write) && !ack_ff;
      if (req.read && !ack_ff) begin
        case (req.address)
          ADDR_CTRL: avs_readdata_ff <= {24'h000000, ctrl_view};
          ADDR_CAUSE: avs_readdata_ff <=
            32'(watchdog_reset_cause_flag_ff) << BIT_CAUSE;
          ADDR_IRQ_STAT: avs_readdata_ff <= 32'(irq_stat_ff);
          ADDR_IRQ_MASK: avs_readdata_ff <= 32'(irq_mask_ff);
          default: avs_readdata_ff <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_irq_ff <= 1'b0;
      sys_reset_ff <= 1'b0;
      irq_out_ff <= 1'b0;
    end else begin
      wdt_irq_ff <= timeout_irq_flag_ff && timeout_irq_enable_ff &&
                    irq_global_en && !irq_fire;
      sys_reset_ff <= rst_fire;
      irq_out_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign avs_readdata = avs_readdata_ff;
  assign wdt_irq = wdt_irq_ff;
  assign irq_vector_addr = VEC_TIMEOUT;
  assign irq_vector_num = VEC_NUM_TIMEOUT;
  assign sys_reset = sys_reset_ff;
  assign reset_vector_addr = VEC_RESET;
  assign irq_out = irq_out_ff;
endmodule
`default_nettype wire

/* test/wdtcfg_assertions.sv */
// Port-level assertions for the watchdog configuration block
`timescale 1ns/1ps
`default_nettype none
module wdtcfg_assertions (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic osc_tick,
  input wire logic wdr_instr,
  input wire logic irq_global_en,
  input wire logic vector_ack,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic wdt_irq,
  input wire logic [15:0] irq_vector_addr,
  input wire logic [5:0] irq_vector_num,
  input wire logic sys_reset,
  input wire logic [15:0] reset_vector_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  vec_const_a: assert property (
    irq_vector_addr == 16'h000c && irq_vector_num == 6'h07)
    else $error("time-out vector wrong");
  reset_vec_a: assert property (reset_vector_addr == 16'h0000)
    else $error("reset vector wrong");
  wait_state_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  idle_ready_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  reset_pulse_a: assert property (sys_reset |=> !sys_reset)
    else $error("reset pulse too long");
  tick_cause_a: assert property (
    sys_reset |-> $past(osc_tick) || $past(osc_tick, 2) ||
      $past(osc_tick, 3))
    else $error("reset without oscillator tick");
  irq_gate_a: assert property (!irq_global_en |=> !wdt_irq)
    else $error("interrupt without global enable");
  vec_clear_a: assert property (
    vector_ack && !osc_tick && $past(!osc_tick) |-> ##3 !wdt_irq)
    else $error("vector did not clear interrupt");
  restart_quiet_a: assert property (wdr_instr |-> ##3 !sys_reset [*8])
    else $error("reset soon after restart");
endmodule
bind wdtcfg_top wdtcfg_assertions u_chk (
  .core_clk(core_clk),
  .rstn(rstn),
  .osc_tick(osc_tick),
  .wdr_instr(wdr_instr),
  .irq_global_en(irq_global_en),
  .vector_ack(vector_ack),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .wdt_irq(wdt_irq),
  .irq_vector_addr(irq_vector_addr),
  .irq_vector_num(irq_vector_num),
  .sys_reset(sys_reset),
  .reset_vector_addr(reset_vector_addr)
);
`default_nettype wire

/* test/test_watchdog_timer_config.sv */
// Register-level testbench for the watchdog configuration block
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timer_config;
  import wdtcfg_pkg::*;
  logic core_clk, rstn, power_on_rst, always_on_fuse, osc_tick, wdr_instr;
  logic irq_global_en, vector_ack, avs_read, avs_write, avs_waitrequest;
  logic wdt_irq, sys_reset, irq_out;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] irq_vector_addr, reset_vector_addr;
  logic [5:0] irq_vector_num;
  int failures, compares, n_rst;
  wdtcfg_top u_dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .power_on_rst(power_on_rst),
    .always_on_fuse(always_on_fuse),
    .osc_tick(osc_tick),
    .wdr_instr(wdr_instr),
    .irq_global_en(irq_global_en),
    .vector_ack(vector_ack),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .wdt_irq(wdt_irq),
    .irq_vector_addr(irq_vector_addr),
    .irq_vector_num(irq_vector_num),
    .sys_reset(sys_reset),
    .reset_vector_addr(reset_vector_addr),
    .irq_out(irq_out)
  );
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (sys_reset === 1'b1) n_rst++;
  task automatic print_verdict();
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Only the watchdog process ends an endless wait
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Oscillator burst, optionally preceded by a watchdog restart
  task automatic osc(input logic w, input int n);
    wdr_instr <= w;
    @(posedge core_clk);
    wdr_instr <= 1'b0;
    osc_tick <= 1'b1;
    repeat (n) @(posedge core_clk);
    osc_tick <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic vec();
    vector_ack <= 1'b1;
    @(posedge core_clk);
    vector_ack <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  initial begin
    #(40 * 40000);
    failures++;
    print_verdict();
  end
  initial begin
    {rstn, power_on_rst, osc_tick, wdr_instr, irq_global_en, vector_ack} = '0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    always_on_fuse = 1'b1;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rc(ADDR_CTRL, 32'hff, 32'h00);
    rc(ADDR_CAUSE, 32'hff, 32'h00);
    rc(4'h2, 32'hffffffff, 32'h0);
    chk(irq_vector_addr, 32'h000c);
    chk(irq_vector_num, 32'h7);
    chk(reset_vector_addr, 32'h0);
    osc(1'b1, 2100);
    chk(n_rst, 0);
    rc(ADDR_IRQ_STAT, 32'h3, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_CTRL, 32'h40);
    irq_global_en <= 1'b1;
    osc(1'b1, 2100);
    chk(n_rst, 0);
    chk({wdt_irq, irq_out}, 2'b11);
    irq_global_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(wdt_irq, 1'b0);
    irq_global_en <= 1'b1;
    rc(ADDR_CTRL, 32'hff, 32'hc0);
    wr(ADDR_CTRL, 32'hc0);
    rc(ADDR_CTRL, 32'hff, 32'h40);
    rc(ADDR_IRQ_STAT, 32'h1, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    rc(ADDR_IRQ_STAT, 32'h1, 32'h0);
    chk(irq_out, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h0);
    osc(1'b1, 2100);
    chk(irq_out, 1'b0);
    vec();
    rc(ADDR_CTRL, 32'hff, 32'h40);
    wr(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_CTRL, 32'h48);
    osc(1'b1, 2100);
    chk(n_rst, 0);
    rc(ADDR_CTRL, 32'hff, 32'hc8);
    vec();
    rc(ADDR_CTRL, 32'hff, 32'h08);
    wr(ADDR_CTRL, 32'h48);
    osc(1'b1, 4200);
    chk(n_rst, 1);
    rc(ADDR_IRQ_STAT, 32'h3, 32'h3);
    rc(ADDR_CAUSE, 32'h08, 32'h08);
    wr(ADDR_CTRL, 32'h18);
    wr(ADDR_CTRL, 32'h00);
    rc(ADDR_CTRL, 32'h08, 32'h08);
    wr(ADDR_CAUSE, 32'h0);
    rc(ADDR_CAUSE, 32'h08, 32'h00);
    wr(ADDR_CTRL, 32'h00);
    rc(ADDR_CTRL, 32'h3f, 32'h08);
    wr(ADDR_CTRL, 32'h18);
    repeat (6) @(posedge core_clk);
    wr(ADDR_CTRL, 32'h00);
    rc(ADDR_CTRL, 32'h3f, 32'h08);
    wr(ADDR_CTRL, 32'h18);
    wr(ADDR_CTRL, 32'h09);
    rc(ADDR_CTRL, 32'h3f, 32'h09);
    osc(1'b1, 2100);
    chk(n_rst, 1);
    osc(1'b1, 2100);
    chk(n_rst, 1);
    osc(1'b0, 2100);
    chk(n_rst, 2);
    wr(ADDR_CAUSE, 32'h0);
    wr(ADDR_CTRL, 32'h18);
    wr(ADDR_CTRL, 32'h28);
    rc(ADDR_CTRL, 32'h3f, 32'h28);
    wr(ADDR_CTRL, 32'h18);
    wr(ADDR_CTRL, 32'h00);
    rc(ADDR_CTRL, 32'h3f, 32'h00);
    always_on_fuse <= 1'b0;
    osc(1'b1, 2100);
    chk(n_rst, 3);
    rc(ADDR_CAUSE, 32'h08, 32'h08);
    power_on_rst <= 1'b1;
    @(posedge core_clk);
    power_on_rst <= 1'b0;
    rc(ADDR_CAUSE, 32'h08, 32'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
